// *** hw/clu_regs.vh ***
// Register map, field positions, reset values and codes of the custom logic unit
`ifndef CLU_REGS_VH
`define CLU_REGS_VH
`define CLU_GLB_OFS 8'h00
`define CLU_SEQ_OFS 8'h04
`define CLU_STAT_OFS 8'h08
`define CLU_T0_FIRST_OFS 8'h10
`define CLU_T0_SECOND_OFS 8'h14
`define CLU_T0_THIRD_OFS 8'h18
`define CLU_T0_TRUTH_OFS 8'h1C
`define CLU_T1_FIRST_OFS 8'h20
`define CLU_T1_SECOND_OFS 8'h24
`define CLU_T1_THIRD_OFS 8'h28
`define CLU_T1_TRUTH_OFS 8'h2C
`define CLU_EN_BIT 0
`define CLU_CLKSEL_BIT 1
`define CLU_FILT_LSB 2
`define CLU_EDGE_BIT 4
`define CLU_IN0_LSB 0
`define CLU_IN1_LSB 4
`define CLU_IN2_LSB 0
`define CLU_SEQ_LSB 0
`define CLU_CTRL_RST 8'h00
`define CLU_TRUTH_RST 8'h00
`define CLU_SEQ_RST 3'h0
`define CLU_SRC_MASK 4'h0
`define CLU_SRC_FEEDBACK 4'h1
`define CLU_SRC_LINK 4'h2
`define CLU_SRC_EVENT0 4'h3
`define CLU_SRC_EVENT1 4'h4
`define CLU_SRC_IO 4'h5
`define CLU_SRC_AC 4'h6
`define CLU_SRC_TIMER0 4'h7
`define CLU_SRC_TIMER1 4'h8
`define CLU_FILT_NONE 2'h0
`define CLU_FILT_SYNC 2'h1
`define CLU_FILT_FILTER 2'h2
`define CLU_SEQ_OFF 3'h0
`define CLU_SEQ_DFF 3'h1
`define CLU_SEQ_JK 3'h2
`define CLU_SEQ_DLATCH 3'h3
`define CLU_SEQ_RS 3'h4
`define CLU_RESP_OKAY 2'h0
`define CLU_RESP_SLVERR 2'h2
`endif

// *** hw/clu_table.v ***
// One lookup table with clock select, output filter and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "clu_regs.vh"
module clu_table (
  input wire clk_sys,
  input wire srst,
  input wire active,
  input wire clk_sel,
  input wire [1:0] filt_sel,
  input wire edge_en,
  input wire [7:0] truth,
  input wire [2:0] in_bits,
  output wire lut_raw,
  output wire tick,
  output wire lut_out
);
  reg in2_d_ff;
  reg [3:0] shift_ff;
  reg filt_ff;
  reg prev_ff;
  wire [2:0] idx;
  wire stage;
  wire sel_v;

  always @(posedge clk_sys)
  begin
    in2_d_ff <= srst ? 1'b0 : in_bits[2];
  end

  // Rising edge of input 2 acts as the table clock
  assign tick = clk_sel ? (in_bits[2] & ~in2_d_ff) : 1'b1;
  // Input 2 reads low while it is the clock
  assign idx = {in_bits[2] & ~clk_sel, in_bits[1:0]};
  assign lut_raw = active & truth[idx];

  always @(posedge clk_sys)
  begin
    if (srst | ~active)
    begin
      shift_ff <= 4'h0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else if (tick)
    begin
      shift_ff <= {shift_ff[2:0], lut_raw};
      // Take a new level only after three equal samples
      if (&shift_ff[3:1] | ~|shift_ff[3:1])
      begin
        filt_ff <= shift_ff[3];
      end
      prev_ff <= stage;
    end
  end

  assign stage = (filt_sel == `CLU_FILT_SYNC) ? shift_ff[1] : filt_ff;
  assign sel_v = (filt_sel == `CLU_FILT_SYNC || filt_sel == `CLU_FILT_FILTER) ?
    stage : lut_raw;
  assign lut_out = edge_en ? (sel_v & ~prev_ff) : sel_v;
endmodule
`default_nettype wire

// *** hw/clu_seq.v ***
// Sequential element of the table pair
`timescale 1ns/1ps
`default_nettype none
`include "clu_regs.vh"
module clu_seq (
  input wire clk_sys,
  input wire srst,
  input wire active,
  input wire tick,
  input wire [2:0] mode,
  input wire d_even,
  input wire d_odd,
  output reg q_ff
);
  always @(posedge clk_sys)
  begin
    if (srst | ~active)
    begin
      q_ff <= 1'b0;
    end
    else
    begin
      case (mode)
        `CLU_SEQ_DFF:
          if (tick & d_odd)
          begin
            q_ff <= d_even;
          end
        `CLU_SEQ_JK:
          if (tick)
          begin
            case ({d_even, d_odd})
              2'b01: q_ff <= 1'b0;
              2'b10: q_ff <= 1'b1;
              2'b11: q_ff <= ~q_ff;
              default: q_ff <= q_ff;
            endcase
          end
        `CLU_SEQ_DLATCH:
          if (d_odd)
          begin
            q_ff <= d_even;
          end
        `CLU_SEQ_RS:
          if (d_even & ~d_odd)
          begin
            q_ff <= 1'b1;
          end
          else if (d_odd & ~d_even)
          begin
            q_ff <= 1'b0;
          end
        default: q_ff <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hw/clu_top.v ***
// Custom logic unit: AXI4-Lite registers, input routing, two tables and sequencer
`timescale 1ns/1ps
`default_nettype none
`include "clu_regs.vh"
module clu_top (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [5:0] pin_in,
  input wire [1:0] event_in,
  input wire comparator_in,
  input wire [1:0] timer_wave_in,
  output reg [1:0] lut_pin_out,
  output reg [1:0] lut_event_out
);
  reg [10:0] sync1_ff;
  reg [10:0] sync2_ff;
  reg aw_full_ff;
  reg w_full_ff;
  reg [7:0] awaddr_ff;
  reg [7:0] wdata_ff;
  reg wstrb_ff;
  reg glb_en_ff;
  reg [2:0] seq_mode_ff;
  reg [1:0] en_ff;
  reg [1:0] clk_ff;
  reg [3:0] filt_ff;
  reg [1:0] edge_ff;
  reg [23:0] sel_ff;
  reg [15:0] truth_ff;
  wire wr_fire;
  wire [3:0] wid;
  wire [2:0] lut_raw;
  wire [1:0] tick;
  wire [1:0] lut_out;
  wire [1:0] act;
  wire [4:0] per;
  wire seq_q;
  integer n;
  genvar g;

  // Register number of an address, 4'hF when unmapped
  function [3:0] reg_id;
    input [7:0] a;
    begin
      case ({a[7:2], 2'b00})
        `CLU_GLB_OFS: reg_id = 4'h0;
        `CLU_SEQ_OFS: reg_id = 4'h1;
        `CLU_STAT_OFS: reg_id = 4'h2;
        `CLU_T0_FIRST_OFS: reg_id = 4'h3;
        `CLU_T0_SECOND_OFS: reg_id = 4'h4;
        `CLU_T0_THIRD_OFS: reg_id = 4'h5;
        `CLU_T0_TRUTH_OFS: reg_id = 4'h6;
        `CLU_T1_FIRST_OFS: reg_id = 4'h7;
        `CLU_T1_SECOND_OFS: reg_id = 4'h8;
        `CLU_T1_THIRD_OFS: reg_id = 4'h9;
        `CLU_T1_TRUTH_OFS: reg_id = 4'hA;
        default: reg_id = 4'hF;
      endcase
    end
  endfunction

  // Register number of field k of table t
  function [3:0] tid;
    input integer t;
    input integer k;
    begin
      tid = 4'h3 + {t[1:0], 2'b00} + k[3:0];
    end
  endfunction

  // Source select of one table input
  function src_pick;
    input [3:0] sel;
    input io;
    input fb;
    input link;
    input [4:0] p;
    begin
      case (sel)
        `CLU_SRC_MASK: src_pick = 1'b0;
        `CLU_SRC_FEEDBACK: src_pick = fb;
        `CLU_SRC_LINK: src_pick = link;
        `CLU_SRC_EVENT0: src_pick = p[2];
        `CLU_SRC_EVENT1: src_pick = p[3];
        `CLU_SRC_IO: src_pick = io;
        `CLU_SRC_AC: src_pick = p[4];
        `CLU_SRC_TIMER0: src_pick = p[0];
        `CLU_SRC_TIMER1: src_pick = p[1];
        default: src_pick = 1'b0;
      endcase
    end
  endfunction

  // Two-stage synchronisers for every outside input
  always @(posedge clk_sys)
  begin
    sync1_ff <= srst ? 11'h000 : {event_in, comparator_in, timer_wave_in, pin_in};
    sync2_ff <= srst ? 11'h000 : sync1_ff;
  end

  // Comparator, event 1, event 0, timer 1, timer 0
  assign per = {sync2_ff[8], sync2_ff[10:9], sync2_ff[7:6]};

  // AXI4-Lite write channel: address and data in either order
  assign wr_fire = aw_full_ff & w_full_ff & ~s_axi_bvalid;
  assign wid = reg_id(awaddr_ff);

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CLU_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_full_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wid == 4'hF || wid == 4'h2) ? `CLU_RESP_SLVERR : `CLU_RESP_OKAY;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers, written on the system clock
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      glb_en_ff <= 1'b0;
      seq_mode_ff <= `CLU_SEQ_RST;
      en_ff <= 2'b00;
      clk_ff <= 2'b00;
      filt_ff <= 4'h0;
      edge_ff <= 2'b00;
      sel_ff <= 24'h000000;
      truth_ff <= {`CLU_TRUTH_RST, `CLU_TRUTH_RST};
    end
    else if (wr_fire & wstrb_ff)
    begin
      if (wid == 4'h0)
      begin
        glb_en_ff <= wdata_ff[`CLU_EN_BIT];
      end
      if (wid == 4'h1 && !en_ff[0])
      begin
        seq_mode_ff <= wdata_ff[`CLU_SEQ_LSB +: 3];
      end
      for (n = 0; n < 2; n = n + 1)
      begin
        if (wid == tid(n, 0))
        begin
          en_ff[n] <= wdata_ff[`CLU_EN_BIT];
          // Protected fields follow only while table is off
          if (!en_ff[n])
          begin
            clk_ff[n] <= wdata_ff[`CLU_CLKSEL_BIT];
            filt_ff[2 * n +: 2] <= wdata_ff[`CLU_FILT_LSB +: 2];
            edge_ff[n] <= wdata_ff[`CLU_EDGE_BIT];
          end
        end
        if (wid == tid(n, 1) && !en_ff[n])
        begin
          sel_ff[12 * n +: 4] <= wdata_ff[`CLU_IN0_LSB +: 4];
          sel_ff[12 * n + 4 +: 4] <= wdata_ff[`CLU_IN1_LSB +: 4];
        end
        if (wid == tid(n, 2) && !en_ff[n])
        begin
          sel_ff[12 * n + 8 +: 4] <= wdata_ff[`CLU_IN2_LSB +: 4];
        end
        if (wid == tid(n, 3))
        begin
          truth_ff[8 * n +: 8] <= wdata_ff;
        end
      end
    end
  end

  // AXI4-Lite read channel, answer one cycle after the address
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CLU_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CLU_RESP_OKAY;
      case (reg_id(s_axi_araddr))
        4'h0: s_axi_rdata <= {31'h00000000, glb_en_ff};
        4'h1: s_axi_rdata <= {29'h00000000, seq_mode_ff};
        4'h2: s_axi_rdata <= {27'h0000000, act, seq_q, lut_out};
        4'h3: s_axi_rdata <= {27'h0000000, edge_ff[0], filt_ff[1:0], clk_ff[0], en_ff[0]};
        4'h4: s_axi_rdata <= {24'h000000, sel_ff[7:0]};
        4'h5: s_axi_rdata <= {28'h0000000, sel_ff[11:8]};
        4'h6: s_axi_rdata <= {24'h000000, truth_ff[7:0]};
        4'h7: s_axi_rdata <= {27'h0000000, edge_ff[1], filt_ff[3:2], clk_ff[1], en_ff[1]};
        4'h8: s_axi_rdata <= {24'h000000, sel_ff[19:12]};
        4'h9: s_axi_rdata <= {28'h0000000, sel_ff[23:20]};
        4'hA: s_axi_rdata <= {24'h000000, truth_ff[15:8]};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CLU_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Link from a missing third table reads low
  assign lut_raw[2] = 1'b0;

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : tbl
      wire [2:0] in_bits;
      assign act[g] = glb_en_ff & en_ff[g];
      assign in_bits[0] = src_pick(sel_ff[12 * g +: 4], sync2_ff[3 * g],
        seq_q, lut_raw[g + 1], per);
      assign in_bits[1] = src_pick(sel_ff[12 * g + 4 +: 4], sync2_ff[3 * g + 1],
        seq_q, lut_raw[g + 1], per);
      // Feedback reaches inputs 0 and 1 only
      assign in_bits[2] = src_pick(sel_ff[12 * g + 8 +: 4], sync2_ff[3 * g + 2],
        1'b0, lut_raw[g + 1], per);
      clu_table u_table (
        .clk_sys(clk_sys),
        .srst(srst),
        .active(act[g]),
        .clk_sel(clk_ff[g]),
        .filt_sel(filt_ff[2 * g +: 2]),
        .edge_en(edge_ff[g]),
        .truth(truth_ff[8 * g +: 8]),
        .in_bits(in_bits),
        .lut_raw(lut_raw[g]),
        .tick(tick[g]),
        .lut_out(lut_out[g])
      );
    end
  endgenerate

  clu_seq u_seq (
    .clk_sys(clk_sys),
    .srst(srst),
    .active(act[0]),
    .tick(tick[0]),
    .mode(seq_mode_ff),
    .d_even(lut_out[0]),
    .d_odd(lut_out[1]),
    .q_ff(seq_q)
  );

  // Outputs to pins and event lines; no halt input, so debug never stops it
  always @(posedge clk_sys)
  begin
    lut_pin_out <= srst ? 2'b00 : lut_out;
    lut_event_out <= srst ? 2'b00 : lut_out;
  end
endmodule
`default_nettype wire

// *** sim/clu_top_checker.sv ***
// Bus and output checks on the custom logic unit ports
`timescale 1ns/1ps
`default_nettype none
module clu_top_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] lut_pin_out,
  input wire logic [1:0] lut_event_out
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_event_mirror: assert property (lut_event_out == lut_pin_out)
    else $error("event outputs differ from pin outputs");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read");
  a_one_write: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write taken during response");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_r_refused: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("bad refused read");
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_out_rise: cover property ($rose(lut_pin_out[1]));
endmodule
bind clu_top clu_top_checker clu_top_checker_i (.clk_sys, .srst, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lut_pin_out, .lut_event_out);
`default_nettype wire

// *** sim/clu_far_end.sv ***
// Pins, event lines, comparator and timers beside the logic unit
`timescale 1ns/1ps
`default_nettype none
module clu_far_end (
  input wire logic clk_sys,
  input wire logic [10:0] want,
  output var logic [5:0] pin_in,
  output var logic [1:0] event_in,
  output var logic comparator_in,
  output var logic [1:0] timer_wave_in
);
  initial
  begin
    {timer_wave_in, comparator_in, event_in, pin_in} = 11'h000;
  end
  // Sources change just after the edge
  always @(posedge clk_sys)
  begin
    {timer_wave_in, comparator_in, event_in, pin_in} <= want;
  end
endmodule
`default_nettype wire

// *** sim/clu_top_test.sv ***
// Self-checking bench for the custom logic unit
`timescale 1ns/1ps
`default_nettype none
`include "clu_regs.vh"
module clu_top_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [10:0] want = 11'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, comparator_in;
  wire [1:0] s_axi_bresp, s_axi_rresp, lut_pin_out, lut_event_out, event_in, timer_wave_in;
  wire [31:0] s_axi_rdata;
  wire [5:0] pin_in;
  integer n_errors = 0;
  integer total_checks = 0;
  integer i;
  integer n_high;
  localparam logic [1:0] ok = `CLU_RESP_OKAY;
  localparam logic [7:0] t0 = `CLU_T0_FIRST_OFS;
  localparam logic [7:0] t1 = `CLU_T1_FIRST_OFS;
  localparam logic [7:0] glb = `CLU_GLB_OFS;
  localparam logic [7:0] seq = `CLU_SEQ_OFS;
  // Row: second control, third control, truth, far-side levels, expected output
  localparam logic [31:0] rows [0:11] = '{
    {8'h05, 4'h0, 8'h02, 11'h001, 1'b1}, {8'h05, 4'h0, 8'h02, 11'h000, 1'b0},
    {8'h03, 4'h0, 8'h02, 11'h040, 1'b1}, {8'h04, 4'h0, 8'h02, 11'h080, 1'b1},
    {8'h06, 4'h0, 8'h02, 11'h100, 1'b1}, {8'h07, 4'h0, 8'h02, 11'h200, 1'b1},
    {8'h08, 4'h0, 8'h02, 11'h400, 1'b1}, {8'h00, 4'h0, 8'h02, 11'h7FF, 1'b0},
    {8'h55, 4'h5, 8'h20, 11'h005, 1'b1}, {8'h55, 4'h5, 8'hDF, 11'h005, 1'b0},
    {8'h55, 4'h5, 8'h10, 11'h004, 1'b1}, {8'h55, 4'h5, 8'h10, 11'h001, 1'b0}};
  clu_top clu_top_i (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_in(pin_in), .event_in(event_in),
    .comparator_in(comparator_in), .timer_wave_in(timer_wave_in),
    .lut_pin_out(lut_pin_out), .lut_event_out(lut_event_out));
  clu_far_end clu_far_end_i (.clk_sys(clk_sys), .want(want), .pin_in(pin_in),
    .event_in(event_in), .comparator_in(comparator_in), .timer_wave_in(timer_wave_in));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    integer k;
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1)
        begin
          s_axi_bready <= 1'b0;
          chk({6'h00, s_axi_bresp}, {6'h00, er});
          k = 99;
        end
      end
      if (k == 50)
        chk(8'h00, 8'hFF);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    integer k;
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1)
        begin
          s_axi_rready <= 1'b0;
          chk(s_axi_rdata[7:0], ed);
          chk({6'h00, s_axi_rresp}, {6'h00, er});
          k = 99;
        end
      end
      if (k == 50)
        chk(8'h00, 8'hFF);
    end
  endtask
  task cfg(input logic [7:0] b, input logic [7:0] sec, input logic [3:0] thr,
    input logic [7:0] tru, input logic [7:0] fst);
    begin
      wr(b, 8'h00, ok);
      wr(b + 8'h04, sec, ok);
      wr(b + 8'h08, {4'h0, thr}, ok);
      wr(b + 8'h0C, tru, ok);
      wr(b, fst, ok);
    end
  endtask
  task pout(input integer n, input logic e);
    begin
      repeat (6) @(posedge clk_sys);
      chk({7'h00, lut_pin_out[n]}, {7'h00, e});
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (i = 0; i < 13; i = i + 1)
      rd(8'(i * 4), 8'h00, (i == 3 || i == 12) ? `CLU_RESP_SLVERR : ok);
    wr(`CLU_STAT_OFS, 8'hFF, `CLU_RESP_SLVERR);
    wr(glb, 8'h01, ok);
    for (i = 0; i < 12; i = i + 1)
    begin
      cfg(t0, rows[i][31:24], rows[i][23:20], rows[i][19:12], 8'h01);
      want <= rows[i][11:1];
      pout(0, rows[i][0]);
    end
    cfg(t0, 8'h05, 4'h0, 8'h02, 8'h01);
    want <= 11'h001;
    pout(0, 1'b1);
    wr(glb, 8'h00, ok);
    pout(0, 1'b0);
    wr(glb, 8'h01, ok);
    pout(0, 1'b1);
    wr(t0, 8'h05, ok);
    rd(t0, 8'h01, ok);
    wr(t0 + 8'h04, 8'h66, ok);
    rd(t0 + 8'h04, 8'h05, ok);
    wr(seq, 8'h02, ok);
    rd(seq, 8'h00, ok);
    wr(t0, 8'h00, ok);
    rd(t0, 8'h00, ok);
    wr(t0, 8'h05, ok);
    rd(t0, 8'h05, ok);
    wr(t0, 8'h00, ok);
    rd(t0, 8'h04, ok);
    pout(0, 1'b0);
    for (i = 4; i > 0; i = i - 1)
    begin
      wr(seq, 8'(i), ok);
      rd(seq, 8'(i), ok);
    end
    cfg(t1, 8'h00, 4'h0, 8'hFF, 8'h01);
    pout(1, 1'b1);
    cfg(t0, 8'h05, 4'h0, 8'h02, 8'h01);
    pout(0, 1'b1);
    rd(`CLU_STAT_OFS, 8'h1F, ok);
    cfg(t1, 8'h01, 4'h0, 8'h02, 8'h01);
    pout(1, 1'b1);
    want <= 11'h000;
    pout(1, 1'b0);
    rd(`CLU_STAT_OFS, 8'h18, ok);
    cfg(t1, 8'h00, 4'h0, 8'hFF, 8'h01);
    cfg(t0, 8'h02, 4'h0, 8'h02, 8'h01);
    pout(0, 1'b1);
    wr(t1 + 8'h0C, 8'h00, ok);
    pout(0, 1'b0);
    wr(glb, 8'h00, ok);
    cfg(t0, 8'h00, 4'h5, 8'h10, 8'h03);
    wr(glb, 8'h01, ok);
    want <= 11'h004;
    pout(0, 1'b0);
    wr(glb, 8'h00, ok);
    cfg(t0, 8'h00, 4'h5, 8'h10, 8'h01);
    wr(glb, 8'h01, ok);
    pout(0, 1'b1);
    // Edge detect behind the sync stage gives one pulse per rise
    cfg(t0, 8'h05, 4'h0, 8'h02, 8'h15);
    want <= 11'h001;
    n_high = 0;
    repeat (10) @(posedge clk_sys) n_high = n_high + lut_pin_out[0];
    chk(n_high[7:0], 8'h01);
    // RS latch: set by even table, then holds
    wr(t0, 8'h00, ok);
    wr(seq, 8'h04, ok);
    cfg(t1, 8'h00, 4'h0, 8'h00, 8'h01);
    cfg(t0, 8'h05, 4'h0, 8'h02, 8'h01);
    pout(0, 1'b1);
    want <= 11'h000;
    pout(0, 1'b0);
    rd(`CLU_STAT_OFS, 8'h1C, ok);
    // Reset in mid-run clears outputs and registers
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    chk({6'h00, lut_pin_out}, 8'h00);
    rd(t1, 8'h00, ok);
    rd(seq, 8'h00, ok);
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule
`default_nettype wire
